// [core/arx_rx.sv]
`timescale 1ns/100ps
module arx_rx
#(
   parameter int US_CYC = arx_pkg::ARX_US_CYC,
   parameter int DEPTH  = arx_pkg::ARX_FIFO_DEPTH
) (
   input  wire logic       I_CLK,
   input  wire logic       I_RESET_N,
   input  wire logic       I_LINE_ONE,
   input  wire logic       I_LINE_ZERO,
   input  wire logic       I_LOW_SPEED,
   input  wire logic       I_LABEL_FILTER_ENABLE,
   input  wire logic       I_CHANNEL_RESET_BIT,
   input  wire logic       I_PARITY_CHECK_ENABLE,
   input  wire logic       I_SDI_DECODER_ENABLE,
   input  wire logic       I_BIT10_COMPARE_VALUE,
   input  wire logic       I_BIT9_COMPARE_VALUE,
   input  wire logic       I_LABEL_ORDER_SELECT,
   input  wire logic       I_LABEL_WR,
   input  wire logic [3:0] I_LABEL_WR_IDX,
   input  wire logic [7:0] I_LABEL_WR_DATA,
   input  wire logic [3:0] I_LABEL_RD_IDX,
   output logic [7:0]      O_LABEL_RD_DATA,
   input  wire logic       I_READ_REQ,
   output logic [31:0]     O_READ_DATA,
   output logic            O_READ_VALID,
   output logic            O_FIFO_EMPTY,
   output logic            O_FIFO_FULL,
   output logic            O_DATA_READY,
   output logic            O_WORD_COMPLETE_STROBE
);
   import arx_pkg::*;

   localparam int FAW = $clog2(DEPTH);

   typedef struct packed {
      logic                    sync1_one;
      logic                    sync1_zero;
      logic                    sync2_one;
      logic                    sync2_zero;
      logic [6:0]              div_cnt;
      logic [2:0]              slow_cnt;
      logic [ARX_SH_W-1:0]     one_sh;
      logic [ARX_SH_W-1:0]     zero_sh;
      logic [ARX_SH_W-1:0]     null_sh;
      arx_state_e              state;
      logic [3:0]              spc_cnt;
      logic [4:0]              bit_cnt;
      logic [ARX_WORD_BITS-1:0] word;
      logic [3:0]              gap_tick;
      logic [1:0]              gap_cnt;
      logic                    word_complete_strobe;
      logic [ARX_LABELS-1:0][ARX_LABEL_W-1:0] labels;
      logic [7:0]              lbl_rd;
      logic [31:0]             rd_data;
      logic                    rd_valid;
      logic                    empty;
      logic                    full;
      logic                    ready;
   } arx_rx_s;

   arx_rx_s r_reg, r_next;

   logic                     f_in_ready;
   logic                     f_out_valid;
   logic [ARX_WORD_BITS-1:0] f_out_data;
   logic [FAW:0]             f_count;
   logic                     tick;
   logic                     bit_one;
   logic                     bit_zero;
   logic                     gap_null;
   logic                     lbl_hit;
   logic                     dec_ok;
   logic                     accept;
   logic                     push;
   logic                     pop;
   logic                     acc;
   logic [ARX_LABEL_W-1:0]   rx_label;

   function automatic logic has_run(input logic [ARX_HALF_W-1:0] v);
      has_run = 1'b0;
      for (int i = 0; i <= ARX_HALF_W - ARX_RUN; i++) begin
         if (&v[i +: ARX_RUN]) begin
            has_run = 1'b1;
         end
      end
   endfunction : has_run

   function automatic logic [7:0] rev8(input logic [7:0] v);
      for (int i = 0; i < 8; i++) begin
         rev8[i] = v[7-i];
      end
   endfunction : rev8

   // Upper half holds the older samples, lower half the newest
   assign bit_one  = has_run(r_reg.one_sh[ARX_SH_W-1:ARX_HALF_W])
                   & has_run(r_reg.null_sh[ARX_HALF_W-1:0]); // [R3]
   assign bit_zero = has_run(r_reg.zero_sh[ARX_SH_W-1:ARX_HALF_W])
                   & has_run(r_reg.null_sh[ARX_HALF_W-1:0]); // [R3]
   assign gap_null = has_run(r_reg.null_sh[ARX_SH_W-1:ARX_HALF_W])
                   & has_run(r_reg.null_sh[ARX_HALF_W-1:0]); // [R4]

   // First received bit is the label MSB; order select is not used here
   assign rx_label = rev8(r_reg.word[ARX_LABEL_W-1:0]); // [R20]

   always_comb begin
      lbl_hit = 1'b0;
      for (int i = 0; i < ARX_LABELS; i++) begin
         if (r_reg.labels[i] == rx_label) begin
            lbl_hit = 1'b1; // [R19]
         end
      end
   end

   assign dec_ok = (r_reg.word[ARX_BIT10_POS] == I_BIT10_COMPARE_VALUE)
                 & (r_reg.word[ARX_BIT9_POS] == I_BIT9_COMPARE_VALUE);
   assign accept = (~I_LABEL_FILTER_ENABLE | lbl_hit)
                 & (~I_SDI_DECODER_ENABLE | dec_ok); // [R11] [R22]
   assign push   = r_reg.word_complete_strobe & accept & ~I_CHANNEL_RESET_BIT;
   assign pop    = I_READ_REQ & f_out_valid & ~I_CHANNEL_RESET_BIT;

   // Sample tick: 1MHz, or every eighth of those at low speed [R24]
   assign tick = (r_reg.div_cnt == 7'(US_CYC - 1))
               & (~I_LOW_SPEED
                  | (r_reg.slow_cnt == 3'(ARX_SLOW_DIV - 1)));

   assign acc = tick & (bit_one | bit_zero)
              & (r_reg.spc_cnt >= 4'(ARX_SPC_MIN))
              & (r_reg.spc_cnt <= 4'(ARX_SPC_MAX)); // [R5]

   always_comb begin
      r_next            = r_reg;
      r_next.sync1_one  = I_LINE_ONE;
      r_next.sync1_zero = I_LINE_ZERO;
      r_next.sync2_one  = r_reg.sync1_one;
      r_next.sync2_zero = r_reg.sync1_zero;
      r_next.word_complete_strobe        = 1'b0;
      r_next.rd_valid   = 1'b0;

      if (r_reg.div_cnt == 7'(US_CYC - 1)) begin
         r_next.div_cnt  = '0;
         r_next.slow_cnt = r_reg.slow_cnt + 1'b1;
      end else begin
         r_next.div_cnt = r_reg.div_cnt + 1'b1;
      end

      if (tick) begin
         // Both comparators high is impossible; it counts as no state
         r_next.one_sh  = {r_reg.one_sh[ARX_SH_W-2:0],
                           r_reg.sync2_one & ~r_reg.sync2_zero}; // [R2]
         r_next.zero_sh = {r_reg.zero_sh[ARX_SH_W-2:0],
                           r_reg.sync2_zero & ~r_reg.sync2_one}; // [R2]
         r_next.null_sh = {r_reg.null_sh[ARX_SH_W-2:0],
                           ~r_reg.sync2_one & ~r_reg.sync2_zero}; // [R2]
         if (r_reg.spc_cnt != 4'hf) begin
            r_next.spc_cnt = r_reg.spc_cnt + 1'b1;
         end
      end

      unique case (r_reg.state)
         ST_GAP: begin
            if (tick) begin
               if (r_reg.gap_tick == 4'(ARX_GAP_SAMPLES - 1)) begin
                  r_next.gap_tick = '0; // [R6]
                  if (!gap_null) begin
                     r_next.gap_cnt = '0;
                  end else if (r_reg.gap_cnt
                               == 2'(ARX_GAP_COUNT - 1)) begin
                     r_next.state   = ST_IDLE; // [R7]
                     r_next.gap_cnt = '0;
                  end else begin
                     r_next.gap_cnt = r_reg.gap_cnt + 1'b1; // [R6]
                  end
               end else begin
                  r_next.gap_tick = r_reg.gap_tick + 1'b1;
               end
            end
         end
         ST_IDLE: begin
            if (tick && (bit_one || bit_zero)) begin
               r_next.word    = '0;
               r_next.word[0] = bit_one;
               r_next.bit_cnt = 5'h01;
               // Accepting sample is the first of the next spacing [R5]
               r_next.spc_cnt = 4'h1;
               r_next.state   = ST_WORD;
            end
         end
         ST_WORD: begin
            if (acc) begin
               r_next.word[r_reg.bit_cnt] = bit_one;
               r_next.spc_cnt             = 4'h1; // [R5]
               r_next.bit_cnt             = r_reg.bit_cnt + 1'b1;
               if (r_reg.bit_cnt == 5'(ARX_WORD_BITS - 1)) begin
                  if (I_PARITY_CHECK_ENABLE) begin
                     // Odd count of ones leaves a 0 in bit 32 [R8]
                     r_next.word[ARX_PARITY_BIT] =
                        ~(^r_next.word);
                  end // Else all bits kept as data [R9]
                  r_next.word_complete_strobe      = 1'b1; // [R10]
                  r_next.state    = ST_GAP;
                  r_next.gap_tick = '0;
                  r_next.gap_cnt  = '0;
               end
            end else if (tick
                         && r_reg.spc_cnt >= 4'(ARX_SPC_MAX)) begin
               // Bit overdue: drop the partial word, no flags [R25] [R5]
               r_next.state    = ST_GAP;
               r_next.gap_tick = '0;
               r_next.gap_cnt  = '0;
            end
         end
      endcase

      if (I_LABEL_WR) begin
         r_next.labels[I_LABEL_WR_IDX] = I_LABEL_WR_DATA; // [R17]
      end
      r_next.lbl_rd = r_reg.labels[I_LABEL_RD_IDX]; // [R21]

      if (pop) begin
         // Oldest word leaves the FIFO on a host read [R14]
         r_next.rd_valid = 1'b1;
         r_next.rd_data  = I_LABEL_ORDER_SELECT ? f_out_data
            : {f_out_data[ARX_WORD_BITS-1:ARX_LABEL_W],
               rev8(f_out_data[ARX_LABEL_W-1:0])};
      end

      // Load wins over a read that empties the FIFO [R13]
      r_next.ready = push | (f_count > (FAW + 1)'(pop));
      r_next.empty = ~r_next.ready; // [R13]
      r_next.full  = (f_count == (FAW + 1)'(DEPTH)) & ~pop
                   | (f_count == (FAW + 1)'(DEPTH - 1))
                     & push & ~pop; // [R15]

      if (I_CHANNEL_RESET_BIT) begin
         // Held here while set; the label table survives [R23]
         r_next.state    = ST_GAP;
         r_next.one_sh   = '0;
         r_next.zero_sh  = '0;
         r_next.null_sh  = '0;
         r_next.spc_cnt  = '0;
         r_next.bit_cnt  = '0;
         r_next.gap_tick = '0;
         r_next.gap_cnt  = '0;
         r_next.word_complete_strobe      = 1'b0;
         r_next.ready    = 1'b0;
         r_next.empty    = 1'b1;
         r_next.full     = 1'b0;
      end
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RESET_N) begin
         r_reg       <= '0;
         r_reg.state <= ST_GAP;
         r_reg.empty <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   // Source never stalls; a full FIFO turns the load into an overwrite
   arx_fifo #(
      .WIDTH (ARX_WORD_BITS),
      .DEPTH (DEPTH)
   ) u_fifo (
      .i_clk       (I_CLK),
      .i_rst_n     (I_RESET_N),
      .i_clear     (I_CHANNEL_RESET_BIT), // [R23]
      .i_in_valid  (push), // [R12]
      .o_in_ready  (f_in_ready),
      .i_in_data   (r_reg.word),
      .i_overwrite (~f_in_ready), // [R16]
      .o_out_valid (f_out_valid),
      .i_out_ready (pop),
      .o_out_data  (f_out_data),
      .o_count     (f_count)
   );

   assign O_LABEL_RD_DATA        = r_reg.lbl_rd;
   assign O_READ_DATA            = r_reg.rd_data;
   assign O_READ_VALID           = r_reg.rd_valid;
   assign O_FIFO_EMPTY           = r_reg.empty;
   assign O_FIFO_FULL            = r_reg.full;
   assign O_DATA_READY           = r_reg.ready;
   assign O_WORD_COMPLETE_STROBE = r_reg.word_complete_strobe;

   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (!I_RESET_N || I_CHANNEL_RESET_BIT);

   sample_excl_a: assert property ( // [R2]
      $onehot({r_reg.one_sh[0], r_reg.zero_sh[0], r_reg.null_sh[0]})
      || !$past(tick) || $past(I_CHANNEL_RESET_BIT))
      else $error("sample registers not mutually exclusive");

   bit_spacing_a: assert property ( // [R5]
      (r_reg.state == ST_WORD && $rose(r_reg.bit_cnt != '0) == 1'b0
       && $changed(r_reg.bit_cnt) && r_reg.bit_cnt != 5'h01)
      |-> $past(r_reg.spc_cnt) >= 4'(ARX_SPC_MIN)
       && $past(r_reg.spc_cnt) <= 4'(ARX_SPC_MAX))
      else $error("bit accepted outside spacing window");

   gap_period_a: assert property ( // [R6]
      r_reg.gap_tick < 4'(ARX_GAP_SAMPLES))
      else $error("gap timer past its period");

   gap_release_a: assert property ( // [R7]
      (r_reg.state == ST_IDLE && $past(r_reg.state) == ST_GAP)
      |-> $past(r_reg.gap_cnt) == 2'(ARX_GAP_COUNT - 1) && $past(gap_null))
      else $error("word started before three gap counts");

   eos_bits_a: assert property ( // [R10]
      r_reg.word_complete_strobe |-> $past(r_reg.bit_cnt) == 5'(ARX_WORD_BITS - 1)
                 && r_reg.state == ST_GAP)
      else $error("strobe without thirty-two bits");

   drop_word_a: assert property ( // [R11]
      (r_reg.word_complete_strobe && !accept) |=> f_count <= $past(f_count))
      else $error("rejected word reached the FIFO");

   empty_clear_a: assert property ( // [R13]
      push |-> ##1 (!O_FIFO_EMPTY && O_DATA_READY))
      else $error("load did not clear empty");

   full_flag_a: assert property ( // [R15]
      (f_count == (FAW + 1)'(DEPTH)) |-> ##1 O_FIFO_FULL || $past(pop))
      else $error("full flag missing at four words");

   abort_word_a: assert property ( // [R25]
      (r_reg.state == ST_WORD && tick && !acc
       && r_reg.spc_cnt >= 4'(ARX_SPC_MAX))
      |=> r_reg.state == ST_GAP && !r_reg.word_complete_strobe)
      else $error("overdue bit did not drop the word");

   chan_reset_a: assert property (@(posedge I_CLK) // [R23]
      disable iff (!I_RESET_N)
      I_CHANNEL_RESET_BIT |=> r_reg.state == ST_GAP && f_count == '0
                          && O_FIFO_EMPTY)
      else $error("channel reset did not clear");

   word_done_c: cover property (r_reg.word_complete_strobe && accept);
   word_drop_c: cover property (r_reg.word_complete_strobe && !accept);
   fifo_full_c: cover property (O_FIFO_FULL && push);
   host_read_c: cover property (O_READ_VALID && O_FIFO_EMPTY);
endmodule : arx_rx

// [core/arx_pkg.sv]
package arx_pkg;
// Functional notes
// R1: Outside logic supplies an accurate 1MHz timing base, under 0.1% error.
// R2: Three 10-bit shift registers sample One, Zero and Null states.
// R3: Bit needs three One or Zero in upper half, three Null below.
// R4: Word gap Null needs three Null samples in both halves.
// R5: Each bit follows the previous one by 8 to 12 samples.
// R6: Gap timer checks Null every 10 samples, incrementing the gap counter.
// R7: No new word starts before the gap counter reaches 3.
// R8: Parity enabled: bit 32 stores 0 for odd ones count, else 1.
// R9: Parity disabled: all 32 received bits stored unchanged.
// R10: Thirty-two valid bits raise the word complete strobe.
// R11: Word stored only if label filter and decoder both pass.
// R12: Accepted words buffer in a four word, 32-bit FIFO.
// R13: Loading sets data ready and clears empty until all words read.
// R14: Host read returns the oldest FIFO word and removes it.
// R15: Full flag is high whenever the FIFO holds four words.
// R16: A word arriving at full FIFO overwrites the newest entry.
// R17: Host writes a 16 entry table of 8-bit accepted labels.
// R18: Host fills spare entries with valid labels before enabling filter.
// R19: Filter on: unmatched words dropped silently, label 00 is ordinary.
// R20: Table compare ignores label order; first written bit meets bit one.
// R21: Host can read back every label table entry.
// R22: Decoder on: bit 10 and bit 9 must equal compare settings.
// R23: Channel reset clears receiver and FIFO, holding channel idle.
// R24: Sample tick is 1MHz at high speed, one eighth at low.
// R25: Bad shape, spacing or gap drops the word without flags.

   localparam int ARX_CLK_NS      = 8;
   localparam int ARX_SAMPLE_NS   = 1000;
   localparam int ARX_US_CYC      = ARX_SAMPLE_NS / ARX_CLK_NS;
   localparam int ARX_SLOW_DIV    = 8;
   localparam int ARX_SH_W        = 10;
   localparam int ARX_HALF_W      = 5;
   localparam int ARX_RUN         = 3;
   localparam int ARX_SPC_MIN     = 8;
   localparam int ARX_SPC_MAX     = 12;
   localparam int ARX_GAP_SAMPLES = 10;
   localparam int ARX_GAP_COUNT   = 3;
   localparam int ARX_WORD_BITS   = 32;
   localparam int ARX_LABEL_W     = 8;
   localparam int ARX_LABELS      = 16;
   localparam int ARX_FIFO_DEPTH  = 4;
   localparam int ARX_PARITY_BIT  = 31;
   localparam int ARX_BIT10_POS   = 9;
   localparam int ARX_BIT9_POS    = 8;

   typedef enum logic [2:0] {
      ST_GAP  = 3'b001,
      ST_IDLE = 3'b010,
      ST_WORD = 3'b100
   } arx_state_e;

endpackage : arx_pkg

// [core/arx_fifo.sv]
`timescale 1ns/100ps
module arx_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 4,
   parameter int AW    = $clog2(DEPTH)
) (
   input  wire logic             i_clk,
   input  wire logic             i_rst_n,
   input  wire logic             i_clear,
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   input  wire logic             i_overwrite,
   output logic                  o_out_valid,
   input  wire logic             i_out_ready,
   output logic [WIDTH-1:0]      o_out_data,
   output logic [AW:0]           o_count
);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wptr;
      logic [AW-1:0]               rptr;
      logic [AW:0]                 count;
   } arx_fifo_s;

   arx_fifo_s r_reg, r_next;
   logic      push, pop, over;

   function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
      inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction : inc

   assign o_in_ready  = (r_reg.count != (AW + 1)'(DEPTH));
   assign o_out_valid = (r_reg.count != '0);
   assign o_out_data  = r_reg.mem[r_reg.rptr];
   assign o_count     = r_reg.count;
   assign push        = i_in_valid & o_in_ready;
   assign pop         = o_out_valid & i_out_ready;
   assign over        = i_in_valid & ~o_in_ready & i_overwrite;

   always_comb begin
      r_next = r_reg;
      if (push) begin
         r_next.mem[r_reg.wptr] = i_in_data;
         r_next.wptr            = inc(r_reg.wptr);
      end
      // Full and still fed: newest entry is replaced, oldest kept [R16]
      if (over) begin
         if (r_reg.wptr == '0) begin
            r_next.mem[DEPTH-1] = i_in_data;
         end else begin
            r_next.mem[r_reg.wptr - 1'b1] = i_in_data;
         end
      end
      if (pop) begin
         r_next.rptr = inc(r_reg.rptr);
      end
      r_next.count = r_reg.count + (AW + 1)'(push) - (AW + 1)'(pop);
      if (i_clear) begin
         r_next.wptr  = '0;
         r_next.rptr  = '0;
         r_next.count = '0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   overwrite_keeps_a: assert property (@(posedge i_clk) // [R16]
      disable iff (!i_rst_n || i_clear)
      (over && !pop) |=> (r_reg.count == (AW + 1)'(DEPTH)))
      else $error("overwrite changed the fill level");
endmodule : arx_fifo

// [dv/arx_tx_model.sv]
`timescale 1ns/100ps
module arx_tx_model #(
   parameter int US_CYC = 2
) (
   input  wire logic        i_clk,
   input  wire logic        i_go,
   input  wire logic [31:0] i_word,
   input  wire logic [4:0]  i_spacing,
   input  wire logic [4:0]  i_high,
   input  wire logic [7:0]  i_gap,
   input  wire logic        i_slow,
   output logic             o_one,
   output logic             o_zero,
   output logic             o_busy
);
   logic [31:0] w;
   int          spc;
   int          hi;
   int          gp;
   logic        sl;

   // Timing is derived from the bench clock, so the line has no drift
   task automatic hold(input int n);
      repeat (n * US_CYC * (sl ? 8 : 1)) @(posedge i_clk);
   endtask : hold

   initial begin
      o_one  = 1'b0;
      o_zero = 1'b0;
      o_busy = 1'b0;
      forever begin
         @(posedge i_clk);
         if (i_go === 1'b1) begin
            w = i_word;
            spc = i_spacing;
            hi = i_high;
            gp = i_gap;
            sl = i_slow;
            o_busy <= 1'b1;
            for (int b = 0; b < 32; b++) begin
               // First bit on the wire lands in word bit 0
               o_one  <= w[b];
               o_zero <= ~w[b];
               hold(hi);
               // Null between bits is also the idle level of the bus
               o_one  <= 1'b0;
               o_zero <= 1'b0;
               hold(spc - hi);
            end
            hold(gp);
            o_busy <= 1'b0;
         end
      end
   end
endmodule : arx_tx_model

// [dv/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
   import arx_pkg::*;
   localparam int US = 2;
   logic        clk, rst_n, one, zero, slow, lf, crst, par, dec, b10, b9;
   logic        ord, lwr, rreq, rvalid, empty, full, ready, stb, go, busy;
   logic [3:0]  lwi, lri;
   logic [7:0]  lwd, lrd, gap;
   logic [4:0]  spc, hi;
   logic [31:0] rdata, word, w;
   logic [31:0] strobes = '0;
   logic [31:0] q[$];
   logic [7:0]  tbl[16] = '{default: 8'h00};
   int          num_errors = 0;
   int          checks = 0;
   int          cyc = 0;
   int          sp_t[5] = '{8, 12, 13, 7, 10};
   int          hi_t[5] = '{4, 6, 6, 4, 2};
   logic        ok_t[5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};

   arx_rx #(.US_CYC(US), .DEPTH(4)) arx_rx_inst (
      .I_CLK(clk), .I_RESET_N(rst_n), .I_LINE_ONE(one), .I_LINE_ZERO(zero),
      .I_LOW_SPEED(slow), .I_LABEL_FILTER_ENABLE(lf),
      .I_CHANNEL_RESET_BIT(crst), .I_PARITY_CHECK_ENABLE(par),
      .I_SDI_DECODER_ENABLE(dec), .I_BIT10_COMPARE_VALUE(b10),
      .I_BIT9_COMPARE_VALUE(b9), .I_LABEL_ORDER_SELECT(ord),
      .I_LABEL_WR(lwr), .I_LABEL_WR_IDX(lwi), .I_LABEL_WR_DATA(lwd),
      .I_LABEL_RD_IDX(lri), .O_LABEL_RD_DATA(lrd), .I_READ_REQ(rreq),
      .O_READ_DATA(rdata), .O_READ_VALID(rvalid), .O_FIFO_EMPTY(empty),
      .O_FIFO_FULL(full), .O_DATA_READY(ready),
      .O_WORD_COMPLETE_STROBE(stb));

   arx_tx_model #(.US_CYC(US)) arx_tx_model_inst (
      .i_clk(clk), .i_go(go), .i_word(word), .i_spacing(spc), .i_high(hi),
      .i_gap(gap), .i_slow(slow), .o_one(one), .o_zero(zero), .o_busy(busy));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic give_verdict();
      if (num_errors == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : give_verdict

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (stb === 1'b1)
         strobes <= strobes + 1;
      if (cyc == 80000) begin
         num_errors++;
         give_verdict();
      end
   end

   function automatic logic [7:0] rev8(input logic [7:0] v);
      logic [7:0] r;
      for (int i = 0; i < 8; i++)
         r[i] = v[7 - i];
      return r;
   endfunction : rev8

   function automatic logic pass(input logic [31:0] x);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < 16; i++)
         if (tbl[i] == rev8(x[7:0]))
            hit = 1'b1;
      return (!lf || hit) && (!dec || (x[9] == b10 && x[8] == b9));
   endfunction : pass

   function automatic logic [31:0] fmt(input logic [31:0] x);
      logic [31:0] r;
      r = x;
      if (par)
         r[31] = ~^x;
      if (!ord)
         r[7:0] = rev8(x[7:0]);
      return r;
   endfunction : fmt

   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] g);
      checks++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic flags();
      chk("fifo_empty", 32'(q.size() == 0), 32'(empty));
      chk("data_ready", 32'(q.size() != 0), 32'(ready));
      chk("fifo_full", 32'(q.size() == 4), 32'(full));
   endtask : flags

   task automatic send(input logic [31:0] x, input int s, input int h,
                       input int g, input logic ok);
      logic [31:0] n;
      n = strobes;
      @(posedge clk);
      go <= 1'b1;
      word <= x;
      spc <= 5'(s);
      hi <= 5'(h);
      gap <= 8'(g);
      @(posedge clk);
      go <= 1'b0;
      repeat (2) @(posedge clk);
      while (busy)
         @(posedge clk);
      #1;
      chk("strobe_count", 32'(ok), strobes - n);
      if (ok && pass(x)) begin
         // A full FIFO keeps its oldest three and loses the newest
         if (q.size() == 4)
            q[3] = fmt(x);
         else
            q.push_back(fmt(x));
      end
      repeat (4) @(posedge clk);
      #1;
      flags();
   endtask : send

   task automatic rd();
      @(posedge clk);
      rreq <= 1'b1;
      @(posedge clk);
      rreq <= 1'b0;
      #1;
      chk("read_valid", 32'(q.size() != 0), 32'(rvalid));
      if (q.size() != 0)
         chk("read_data", q.pop_front(), rdata);
      @(posedge clk);
      #1;
      flags();
   endtask : rd

   task automatic lw(input logic [3:0] i, input logic [7:0] d);
      @(posedge clk);
      lwr <= 1'b1;
      lwi <= i;
      lwd <= d;
      @(posedge clk);
      lwr <= 1'b0;
   endtask : lw

   initial begin
      {go, lwr, rreq, crst, slow, lf, par, dec, b10, b9} = '0;
      ord = 1'b1;
      {word, lwi, lwd, lri} = '0;
      spc = 5'd10;
      hi = 5'd5;
      gap = 8'd50;
      rst_n = 1'b0;
      void'($urandom(23));
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (100) @(posedge clk);
      flags();
      for (int m = 0; m < 4; m++) begin
         par <= m[0];
         ord <= m[1];
         send($urandom(), 10, 5, 50, 1'b1);
         rd();
      end
      foreach (sp_t[i])
         send($urandom(), sp_t[i], hi_t[i], 50, ok_t[i]);
      repeat (3) rd();
      send($urandom(), 10, 5, 0, 1'b1);
      send($urandom(), 10, 5, 50, 1'b0);
      rd();
      repeat (5) send($urandom(), 10, 5, 50, 1'b1);
      repeat (5) rd();
      // Every entry is loaded before filtering is switched on
      foreach (tbl[i]) begin
         tbl[i] = (i == 0) ? 8'h00 : 8'($urandom());
         lw(4'(i), tbl[i]);
      end
      foreach (tbl[i]) begin
         @(posedge clk);
         lri <= 4'(i);
         repeat (2) @(posedge clk);
         #1;
         chk("label_entry", 32'(tbl[i]), 32'(lrd));
      end
      lf <= 1'b1;
      for (int m = 0; m < 6; m++) begin
         ord <= m[0];
         w = $urandom();
         if (m < 3)
            w[7:0] = rev8(tbl[m * 5]);
         send(w, 10, 5, 50, 1'b1);
         rd();
      end
      lf <= 1'b0;
      dec <= 1'b1;
      for (int m = 0; m < 16; m++) begin
         {b10, b9} <= m[3:2];
         w = $urandom();
         w[9:8] = m[1:0];
         send(w, 10, 5, 50, 1'b1);
         rd();
      end
      dec <= 1'b0;
      repeat (2) send($urandom(), 10, 5, 50, 1'b1);
      crst <= 1'b1;
      repeat (4) @(posedge clk);
      q.delete();
      flags();
      send($urandom(), 10, 5, 50, 1'b0);
      crst <= 1'b0;
      rd();
      repeat (100) @(posedge clk);
      slow <= 1'b1;
      repeat (800) @(posedge clk);
      send($urandom(), 10, 5, 50, 1'b1);
      rd();
      give_verdict();
   end
endmodule : tb_top
